// ---- hdl/sarcs_map.svh ----
`ifndef SARCS_MAP_SVH
`define SARCS_MAP_SVH

// ==========================================
// Function codes
`define SARCS_FUNC_START 3'h1

// ==========================================
// Field positions
`define SARCS_SIGN_POS 12
`define SARCS_MAG_MSB 11
`define SARCS_EXT_LSB 12
`define SARCS_EXT_MSB 15

// ==========================================
// Preset, reset and compare values
`define SARCS_SR_LOAD 12'h7ff
`define SARCS_SR_LAST 12'hffe
`define SARCS_SR_IDLE 12'hfff
`define SARCS_SW_IDLE 13'h0fff
`define SARCS_DATA_N_RST 16'hffff
`define SARCS_EXT_ONES 4'hf
`define SARCS_EXT_ZERO 4'h0

`endif

// ---- hdl/sarcs_pkg.sv ----
package sarcs_pkg;

    // ==========================================
    // Types
    typedef logic [15:0] sarcs_word_t;
    typedef logic [12:0] sarcs_sw_t;
    typedef logic [2:0] sarcs_func_t;

    typedef enum logic [3:0] {
        SARCS_ST_SAMPLE = 4'b0001,
        SARCS_ST_HOLD = 4'b0010,
        SARCS_ST_CONV = 4'b0100,
        SARCS_ST_STORE = 4'b1000
    } sarcs_state_t;

endpackage : sarcs_pkg

// ---- hdl/sarcs_sequencer.sv ----
`timescale 1ns/1ns
`include "sarcs_map.svh"
module sarcs_sequencer #(
    parameter int CONV_DIV = 8,
    parameter int TIMER_W = 16
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Host bus function decode
    input wire logic i_func_strobe_n,
    input wire sarcs_pkg::sarcs_func_t i_func_code_n,
    // Comparator
    input wire logic i_comp,
    // Timer time base
    input wire logic i_osc_1mhz,
    input wire logic i_ext_tb_n,
    input wire logic i_tb_ext_sel,
    // Host facing status and data
    output logic o_busy_n,
    output logic o_data_ready_n,
    output sarcs_pkg::sarcs_word_t o_data_n,
    // Converter internals
    output sarcs_pkg::sarcs_sw_t o_switch,
    output logic o_hold,
    output logic o_sample,
    output logic o_store,
    output logic [TIMER_W-1:0] o_timer_count
);
    import sarcs_pkg::*;
    localparam int DW = (CONV_DIV > 2) ? $clog2(CONV_DIV) : 1;

    // ==========================================
    // Helpers
    function automatic sarcs_word_t sarcs_result_n(
        input logic [12:0] ff
    );
        sarcs_word_t w;
        w = {{3{~ff[`SARCS_SIGN_POS]}}, ~ff};
        sarcs_result_n = ~w;
    endfunction : sarcs_result_n

    // ==========================================
    // Synchronisers
    logic strobe_s1, strobe_s2, strobe_s3;
    sarcs_func_t func_s1, func_s2;
    logic comp_s1, comp_s2;
    logic osc_s1, osc_s2, osc_s3;
    logic ext_s1, ext_s2, ext_s3;
    logic sel_s1, sel_s2;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            strobe_s1 <= 1'b1;
            strobe_s2 <= 1'b1;
            strobe_s3 <= 1'b1;
            func_s1 <= '1;
            func_s2 <= '1;
        end else begin
            strobe_s1 <= i_func_strobe_n;
            strobe_s2 <= strobe_s1;
            strobe_s3 <= strobe_s2;
            func_s1 <= i_func_code_n;
            func_s2 <= func_s1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            comp_s1 <= 1'b0;
            comp_s2 <= 1'b0;
        end else begin
            comp_s1 <= i_comp;
            comp_s2 <= comp_s1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
            ext_s1 <= 1'b1;
            ext_s2 <= 1'b1;
            ext_s3 <= 1'b1;
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
        end else begin
            osc_s1 <= i_osc_1mhz;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
            ext_s1 <= i_ext_tb_n;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            sel_s1 <= i_tb_ext_sel;
            sel_s2 <= sel_s1;
        end
    end

    // ==========================================
    // Start decode
    logic start_go, tb_rise;
    sarcs_state_t state_reg;
    logic [11:0] sr_reg;

    // Host pins are ground true
    assign start_go = strobe_s3 && !strobe_s2 &&
        (~func_s2 == `SARCS_FUNC_START) &&
        (state_reg == SARCS_ST_SAMPLE);

    assign tb_rise = sel_s2 ? (ext_s3 && !ext_s2)
                            : (!osc_s3 && osc_s2);

    // ==========================================
    // Conversion clock
    logic [DW-1:0] div_reg;
    logic lead, trail;

    assign lead = (div_reg == '0);
    assign trail = (div_reg == DW'(CONV_DIV / 2));

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            div_reg <= '0;
        end else if (div_reg == DW'(CONV_DIV - 1)) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    // ==========================================
    // Control state
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state_reg <= SARCS_ST_SAMPLE;
            o_hold <= 1'b0;
            o_sample <= 1'b1;
            o_busy_n <= 1'b1;
            o_store <= 1'b0;
        end else begin
            case (state_reg)
                SARCS_ST_SAMPLE: begin
                    if (start_go) begin
                        state_reg <= SARCS_ST_HOLD;
                        o_hold <= 1'b1;
                        o_busy_n <= 1'b0;
                    end
                end
                SARCS_ST_HOLD: begin
                    if (lead) begin
                        state_reg <= SARCS_ST_CONV;
                        o_sample <= 1'b0;
                    end
                end
                SARCS_ST_CONV: begin
                    if (trail && sr_reg == `SARCS_SR_LAST) begin
                        state_reg <= SARCS_ST_STORE;
                        o_store <= 1'b1;
                    end
                end
                SARCS_ST_STORE: begin
                    if (trail) begin
                        state_reg <= SARCS_ST_SAMPLE;
                        o_sample <= 1'b1;
                        o_hold <= 1'b0;
                        o_busy_n <= 1'b1;
                        o_store <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= SARCS_ST_SAMPLE;
                end
            endcase
        end
    end

    // ==========================================
    // Shift register and bit flops
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            sr_reg <= `SARCS_SR_IDLE;
        end else if (start_go) begin
            sr_reg <= `SARCS_SR_LOAD;
        end else if (state_reg == SARCS_ST_CONV && trail) begin
            sr_reg <= {1'b1, sr_reg[11:1]};
        end
    end

    // Bits 12..1 are flops, bit 0 is the direct switch
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_switch <= `SARCS_SW_IDLE;
        end else if (state_reg == SARCS_ST_SAMPLE) begin
            o_switch <= `SARCS_SW_IDLE;
        end else if (state_reg == SARCS_ST_CONV && trail) begin
            for (int p = 1; p <= `SARCS_MAG_MSB; p++) begin
                if (!sr_reg[p]) begin
                    o_switch[p] <= 1'b0;
                    o_switch[p+1] <= comp_s2;
                end
            end
            if (!sr_reg[0]) begin
                o_switch[0] <= 1'b0;
                o_switch[1] <= comp_s2;
            end
        end
    end

    // ==========================================
    // Data buffer
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_data_n <= `SARCS_DATA_N_RST;
        end else if (state_reg == SARCS_ST_STORE && trail) begin
            // Bit 0 flop captures here as the buffer cell
            o_data_n <= sarcs_result_n(
                {o_switch[12:1], comp_s2});
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_data_ready_n <= 1'b1;
        end else if (state_reg == SARCS_ST_STORE && trail) begin
            o_data_ready_n <= 1'b0;
        end else if (start_go) begin
            o_data_ready_n <= 1'b1;
        end
    end

    // ==========================================
    // Timer
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_timer_count <= '0;
        end else if (tb_rise) begin
            o_timer_count <= o_timer_count + 1'b1;
        end
    end

    // ==========================================
    // Assertions
    property p_sign_ext;
        @(posedge i_clk) disable iff (!i_resetn)
        (o_data_n[`SARCS_EXT_MSB:`SARCS_EXT_LSB] == `SARCS_EXT_ONES ||
         o_data_n[`SARCS_EXT_MSB:`SARCS_EXT_LSB] == `SARCS_EXT_ZERO);
    endproperty
    a_sign_ext: assert property (p_sign_ext)
        else $error("sign extension bits differ");
    property p_idle_sw;
        @(posedge i_clk) disable iff (!i_resetn)
        (state_reg == SARCS_ST_SAMPLE) ##1
        (state_reg == SARCS_ST_SAMPLE) |-> o_switch == `SARCS_SW_IDLE;
    endproperty
    a_idle_sw: assert property (p_idle_sw)
        else $error("switches not preset between conversions");
    property p_start;
        @(posedge i_clk) disable iff (!i_resetn)
        start_go |=> o_hold && !o_busy_n && sr_reg == `SARCS_SR_LOAD;
    endproperty
    a_start: assert property (p_start)
        else $error("start did not set hold and load shifter");
    property p_first_edge;
        @(posedge i_clk) disable iff (!i_resetn)
        (state_reg == SARCS_ST_CONV && trail &&
         sr_reg == `SARCS_SR_LOAD) |=>
        !o_switch[11] && o_switch[12] == $past(comp_s2);
    endproperty
    a_first_edge: assert property (p_first_edge)
        else $error("first edge did not decide sign");
    property p_twelve_edges;
        @(posedge i_clk) disable iff (!i_resetn)
        (state_reg == SARCS_ST_CONV && trail &&
         sr_reg == `SARCS_SR_LAST) |=>
        state_reg == SARCS_ST_STORE && !o_switch[0] && o_store;
    endproperty
    a_twelve_edges: assert property (p_twelve_edges)
        else $error("twelfth edge did not open bit 0 and store");
    property p_store_end;
        @(posedge i_clk) disable iff (!i_resetn)
        (state_reg == SARCS_ST_STORE && trail) |=>
        state_reg == SARCS_ST_SAMPLE && o_sample && o_busy_n &&
        o_data_n[0] == $past(comp_s2);
    endproperty
    a_store_end: assert property (p_store_end)
        else $error("store did not end busy or capture bit 0");
    property p_invert;
        @(posedge i_clk) disable iff (!i_resetn)
        (state_reg == SARCS_ST_STORE && trail) |=>
        o_data_n[12:1] == $past(o_switch[12:1]) &&
        !o_data_ready_n;
    endproperty
    a_invert: assert property (p_invert)
        else $error("buffer not loaded from inverted flops");
    property p_hold_data;
        @(posedge i_clk) disable iff (!i_resetn)
        !(state_reg == SARCS_ST_STORE && trail) |=> $stable(o_data_n);
    endproperty
    a_hold_data: assert property (p_hold_data)
        else $error("buffer changed outside store");
    property p_timer;
        @(posedge i_clk) disable iff (!i_resetn)
        tb_rise |=> o_timer_count == $past(o_timer_count) + 1'b1;
    endproperty
    a_timer: assert property (p_timer)
        else $error("timer missed a time base edge");
    property p_shift;
        @(posedge i_clk) disable iff (!i_resetn)
        (state_reg == SARCS_ST_CONV && trail && !sr_reg[5]) |=>
        !o_switch[5] && o_switch[6] == $past(comp_s2) && !sr_reg[4];
    endproperty
    a_shift: assert property (p_shift)
        else $error("zero did not advance one place");

endmodule : sarcs_sequencer

// ---- hdl/sarcs_sequencer_unused_placeholder_none.sv ----
`timescale 1ns/1ns

// ---- verif/sarcs_front_model.sv ----
`timescale 1ns/1ns
// ====
// Host start command and comparator
module sarcs_front_model (
    // Clock and bench control
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [2:0] i_code,
    input wire logic [12:0] i_target,
    input wire logic [12:0] i_switch,
    // Sequencer side
    output logic o_strobe_n,
    output logic [2:0] o_code_n,
    output logic o_comp
);
    logic [2:0] cnt_reg = 3'h0;
    logic [2:0] code_reg = 3'h0;
    always_ff @(posedge i_clk) begin
        if (i_go) begin
            cnt_reg <= 3'h6;
            code_reg <= ~i_code;
        end else if (cnt_reg != 3'h0) begin
            cnt_reg <= cnt_reg - 3'h1;
        end
    end
    // Code steady around strobe, pulled up when released
    assign o_strobe_n = !(cnt_reg >= 3'h2 && cnt_reg <= 3'h5);
    assign o_code_n = (cnt_reg != 3'h0) ? code_reg : 3'h7;
    // Greedy trial of switch pattern against target
    assign o_comp = (~i_switch > i_target);
endmodule : sarcs_front_model

// ---- verif/test_sarcs_sequencer.sv ----
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected at %0t got %h exp %h", $time, (g), (e)); end end
// ====
// Bench
module test_sarcs_sequencer;
    import sarcs_pkg::*;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_osc_1mhz = 1'b0;
    logic i_ext_tb_n = 1'b1;
    logic i_tb_ext_sel = 1'b0;
    logic go = 1'b0;
    logic [2:0] code = 3'h1;
    logic [12:0] target = 13'h0;
    logic strobe_n, comp;
    sarcs_func_t code_n;
    logic o_busy_n, o_data_ready_n, o_hold, o_sample, o_store;
    sarcs_word_t o_data_n;
    sarcs_sw_t o_switch;
    logic [15:0] o_timer_count;
    logic [6:0] osc_cnt = 7'h0;
    logic [12:0] pats [7] = '{13'h0fff, 13'h1000, 13'h0000, 13'h1fff,
        13'h0800, 13'h1555, 13'h0001};
    int miscompares = 0;
    int n_checks = 0;

    sarcs_sequencer #(.CONV_DIV(8), .TIMER_W(16)) u_dut (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_func_strobe_n(strobe_n),
        .i_func_code_n(code_n), .i_comp(comp), .i_osc_1mhz(i_osc_1mhz),
        .i_ext_tb_n(i_ext_tb_n), .i_tb_ext_sel(i_tb_ext_sel),
        .o_busy_n(o_busy_n), .o_data_ready_n(o_data_ready_n),
        .o_data_n(o_data_n), .o_switch(o_switch), .o_hold(o_hold),
        .o_sample(o_sample), .o_store(o_store),
        .o_timer_count(o_timer_count));
    sarcs_front_model u_front (.i_clk(i_clk), .i_go(go), .i_code(code),
        .i_target(target), .i_switch(o_switch), .o_strobe_n(strobe_n),
        .o_code_n(code_n), .o_comp(comp));

    initial begin
        forever #4 i_clk = ~i_clk;
    end

    // 1 MHz time base
    always @(posedge i_clk) begin
        osc_cnt <= (osc_cnt == 7'h7c) ? 7'h0 : osc_cnt + 7'h1;
        i_osc_1mhz <= (osc_cnt < 7'h3e);
    end

    // ====
    // Shared tasks
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask : tick

    task automatic start(input logic [2:0] c, input logic [12:0] p);
        @(posedge i_clk);
        code <= c;
        target <= p;
        go <= 1'b1;
        @(posedge i_clk);
        go <= 1'b0;
    endtask : start

    task automatic wait_busy(input logic lvl);
        int i;
        for (i = 0; i < 300 && o_busy_n !== lvl; i++) @(negedge i_clk);
        `CHK(o_busy_n, lvl)
    endtask : wait_busy

    task automatic test_done;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    // ====
    // Scenarios
    task automatic t_reset_vals;
        `CHK(o_busy_n, 1'b1)
        `CHK(o_data_ready_n, 1'b1)
        `CHK(o_data_n, 16'hffff)
        `CHK(o_switch, 13'h0fff)
        `CHK({o_hold, o_sample, o_store}, 3'h2)
        `CHK(o_timer_count, 16'h0)
    endtask : t_reset_vals

    task automatic t_convert(input logic [12:0] p);
        int i;
        logic [7:0] st;
        logic sw0;
        st = 8'h0;
        sw0 = 1'b1;
        start(3'h1, p);
        wait_busy(1'b0);
        `CHK(o_hold, 1'b1)
        for (i = 0; i < 20 && o_switch === 13'h0fff; i++) @(negedge i_clk);
        `CHK(o_switch, {~p[12], 12'h7ff})
        for (i = 0; i < 200 && o_busy_n !== 1'b1; i++) begin
            st += o_store;
            sw0 &= o_switch[0];
            @(negedge i_clk);
        end
        `CHK(st, 8'h8)
        `CHK(sw0, 1'b0)
        `CHK(o_data_n, ~{{3{p[12]}}, p})
        `CHK(o_data_n[15:12], {4{~p[12]}})
        `CHK({o_busy_n, o_data_ready_n, o_hold, o_sample}, 4'h9)
        tick(1);
        `CHK(o_switch, 13'h0fff)
    endtask : t_convert

    task automatic t_refuse;
        int i;
        for (i = 0; i < 8; i++) begin
            if (i != 1) begin
                start(3'(i), 13'h0123);
                tick(12);
                `CHK({o_busy_n, o_data_ready_n}, 2'h2)
            end
        end
        start(3'h1, 13'h0abc);
        wait_busy(1'b0);
        start(3'h1, 13'h0abc);
        wait_busy(1'b1);
        tick(30);
        `CHK(o_busy_n, 1'b1)
        `CHK(o_data_n, 16'hf543)
        @(posedge i_clk);
        target <= 13'h1555;
        tick(40);
        `CHK(o_data_n, 16'hf543)
    endtask : t_refuse

    task automatic t_timer;
        logic [15:0] c0;
        tick(2);
        c0 = o_timer_count;
        tick(625);
        `CHK(16'(o_timer_count - c0), 16'h5)
        @(posedge i_clk) i_tb_ext_sel <= 1'b1;
        tick(8);
        c0 = o_timer_count;
        repeat (4) begin
            @(posedge i_clk) i_ext_tb_n <= 1'b0;
            tick(4);
            @(posedge i_clk) i_ext_tb_n <= 1'b1;
            tick(4);
        end
        tick(6);
        `CHK(16'(o_timer_count - c0), 16'h4)
        @(posedge i_clk) i_tb_ext_sel <= 1'b0;
    endtask : t_timer

    task automatic t_midreset;
        start(3'h1, 13'h1234);
        wait_busy(1'b0);
        tick(30);
        @(posedge i_clk) i_resetn <= 1'b0;
        tick(3);
        t_reset_vals();
        @(posedge i_clk) i_resetn <= 1'b1;
    endtask : t_midreset

    // ====
    // Main sequence and watchdog
    initial begin
        repeat (6) @(posedge i_clk);
        tick(1);
        t_reset_vals();
        @(posedge i_clk) i_resetn <= 1'b1;
        tick(4);
        foreach (pats[k]) t_convert(pats[k]);
        t_refuse();
        t_timer();
        t_midreset();
        tick(4);
        t_convert(13'h0aaa);
        test_done();
    end

    initial begin
        #160000;
        miscompares++;
        test_done();
    end
endmodule : test_sarcs_sequencer
